// [cbs_pkg.sv]
// Shared constants and types for the card socket signalling block.
// Assumes a 100 MHz system clock; all timing counts derive from it.
package cbs_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int CCLK_PERIOD_NS = 160;
	localparam int CCLK_HALF_CYC = CCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int DEBOUNCE_NS = 1000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CRST_HOLD_NS = 2000;
	localparam int CRST_HOLD_CYC = (CRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Data path
	// ************************************************************
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = DATA_W + BE_W;

	// ************************************************************
	// Bus commands (high three bits select the kind)
	// ************************************************************
	localparam logic [3:0] CMD_IO_READ = 4'h2;
	localparam logic [3:0] CMD_IO_WRITE = 4'h3;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_CFG_READ = 4'ha;
	localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

	// ************************************************************
	// Card kinds
	// ************************************************************
	typedef enum logic [1:0] {
		CBS_CARD_NONE,
		CBS_CARD_16BIT,
		CBS_CARD_CARDBUS,
		CBS_CARD_UNKNOWN
	} cbs_card_type;
endpackage : cbs_pkg

// [cbs_fifo.sv]
// Write data buffer between the user port and the card bus engine.
// Assumes one clock domain; both sides use valid/ready.
`timescale 1ns/10ps
module cbs_fifo #(
	parameter int WIDTH = cbs_pkg::FIFO_W,
	parameter int DEPTH = cbs_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0] count_reg, count_next;
	logic push, pop;

	assign in_ready = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		if (push) begin
			wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
		end
		if (pop) begin
			rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
		end
		if (push & !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop & !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
		end
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end
endmodule : cbs_fifo

// [cbs_socket.sv]
// Socket side of a bridge toward an inserted card: detect, status, clock, reset, bus master.
// Assumes pins are asynchronous to clk_sys; tri-state wires are resolved outside.
//
// Notes on behaviour
// - The bridge makes the card clock and takes card bus inputs on its rising edge, except the listed async pins.
// - The bridge shows on the clock-run line whether the host-side bus clock is running; the drive here is only while a settled bus card is present.
// - The bridge holds card reset low to bring the card to a known state, and the card then idles its outputs.
// - A transaction is one address phase followed by one or more data phases, for reads and writes.
// - The address is 32 bits, a byte address for I/O and a double-word address for memory and configuration.
// - In data phases the low byte is on lines 7 to 0 and the high byte on lines 31 to 24.
// - Write data is valid with initiator ready, read data with target ready, and moves only when both are low.
// - Enable line 0 qualifies byte lane 0 and line 3 lane 3, both active low.
// - Insertion is seen on the two low-true detect inputs and the type comes from them with the two sense lines; the decode here uses only vs[0].
// - Status input 1 is battery detect 1 on a memory card and status change or ring on an I/O card.
// - Status input 2 is battery detect 2 on a memory card and speaker or LED on an I/O card.
`timescale 1ns/10ps
module cbs_socket #(
	parameter int FIFO_DEPTH = cbs_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] cd_n_pin,
	input wire logic [1:0] vs_pin,
	input wire logic mfs1_pin,
	input wire logic mfs2_pin,
	input wire logic io_card_mode,
	output logic card_present,
	output logic [1:0] card_type,
	output logic type_valid,
	output logic bvd1,
	output logic bvd2,
	output logic stschg_ri,
	output logic spkr_led,
	input wire logic host_clk_running,
	output logic card_clk_req,
	output logic cclk,
	input wire logic clkrun_n_in,
	output logic clkrun_n_out,
	output logic clkrun_n_oe,
	output logic crst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [3:0] req_cmd,
	input wire logic [31:0] req_addr,
	input wire logic [3:0] req_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	output logic rd_valid,
	output logic [31:0] rd_data,
	input wire logic [31:0] cad_in,
	output logic [31:0] cad_out,
	output logic cad_oe,
	output logic [3:0] cbe_n_out,
	output logic cbe_n_oe,
	output logic frame_n_out,
	output logic frame_n_oe,
	output logic irdy_n_out,
	output logic irdy_n_oe,
	input wire logic trdy_n_in
);
	localparam int HALF = cbs_pkg::CCLK_HALF_CYC;
	localparam int DW = $clog2(HALF);
	localparam int BW = $clog2(cbs_pkg::DEBOUNCE_CYC + 1);
	localparam int RW = $clog2(cbs_pkg::CRST_HOLD_CYC + 1);
	localparam int SW = 40;

	function automatic cbs_pkg::cbs_card_type decode_type(input logic [1:0] cd_n, input logic [1:0] vs);
		if (cd_n == 2'b11) begin
			decode_type = cbs_pkg::CBS_CARD_NONE;
		end else if (cd_n != 2'b00) begin
			decode_type = cbs_pkg::CBS_CARD_UNKNOWN;
		end else if (vs[0]) begin
			decode_type = cbs_pkg::CBS_CARD_16BIT;
		end else begin
			decode_type = cbs_pkg::CBS_CARD_CARDBUS;
		end
	endfunction : decode_type

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [SW-1:0] meta_reg, sync_reg;
	logic [1:0] cd_n_s, vs_s;
	logic mfs1_s, mfs2_s, clkrun_n_s, trdy_n_s;
	logic [31:0] cad_s;

	always_ff @(posedge clk_sys) begin
		meta_reg <= {cd_n_pin, vs_pin, mfs1_pin, mfs2_pin, clkrun_n_in, trdy_n_in, cad_in};
		sync_reg <= meta_reg;
	end
	assign {cd_n_s, vs_s, mfs1_s, mfs2_s, clkrun_n_s, trdy_n_s, cad_s} = sync_reg;

	// ************************************************************
	// Detect, type decode, status pins, card reset
	// ************************************************************
	cbs_pkg::cbs_card_type type_reg, type_next;
	logic [3:0] last_reg, last_next;
	logic [BW-1:0] deb_reg, deb_next;
	logic [RW-1:0] rst_cnt_reg, rst_cnt_next;
	logic valid_reg, valid_next, crst_n_reg, crst_n_next;
	logic bvd1_reg, bvd1_next, bvd2_reg, bvd2_next, sts_reg, sts_next, spk_reg, spk_next;
	logic is_cb, cclk_rise;

	always_comb begin
		last_next = {cd_n_s, vs_s};
		deb_next = deb_reg;
		type_next = type_reg;
		valid_next = valid_reg;
		rst_cnt_next = rst_cnt_reg;
		crst_n_next = crst_n_reg;
		bvd1_next = 1'b0;
		bvd2_next = 1'b0;
		sts_next = 1'b0;
		spk_next = 1'b0;
		// Any change restarts settling so contact bounce never yields a type
		if (last_next != last_reg) begin
			deb_next = '0;
			valid_next = 1'b0;
		end else if (deb_reg != BW'(cbs_pkg::DEBOUNCE_CYC)) begin
			deb_next = deb_reg + 1'b1;
		end else begin
			type_next = decode_type(cd_n_s, vs_s);
			valid_next = 1'b1;
		end
		// Reset released only after a settled bus card with its clock ticking
		if (!valid_reg || type_reg != cbs_pkg::CBS_CARD_CARDBUS) begin
			rst_cnt_next = '0;
			crst_n_next = 1'b0;
		end else if (rst_cnt_reg != RW'(cbs_pkg::CRST_HOLD_CYC)) begin
			rst_cnt_next = rst_cnt_reg + 1'b1;
		end else begin
			crst_n_next = 1'b1;
		end
		if (valid_reg && type_reg == cbs_pkg::CBS_CARD_16BIT) begin
			if (io_card_mode) begin
				sts_next = !mfs1_s;
				spk_next = mfs2_s;
			end else begin
				bvd1_next = mfs1_s;
				bvd2_next = mfs2_s;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			last_reg <= 4'hf;
			deb_reg <= '0;
			type_reg <= cbs_pkg::CBS_CARD_NONE;
			valid_reg <= 1'b0;
			rst_cnt_reg <= '0;
			crst_n_reg <= 1'b0;
			bvd1_reg <= 1'b0;
			bvd2_reg <= 1'b0;
			sts_reg <= 1'b0;
			spk_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
			deb_reg <= deb_next;
			type_reg <= type_next;
			valid_reg <= valid_next;
			rst_cnt_reg <= rst_cnt_next;
			crst_n_reg <= crst_n_next;
			bvd1_reg <= bvd1_next;
			bvd2_reg <= bvd2_next;
			sts_reg <= sts_next;
			spk_reg <= spk_next;
		end
	end

	assign is_cb = valid_reg && type_reg == cbs_pkg::CBS_CARD_CARDBUS;
	assign card_present = valid_reg && type_reg != cbs_pkg::CBS_CARD_NONE;
	assign card_type = type_reg;
	assign type_valid = valid_reg;
	assign crst_n = crst_n_reg;
	assign {bvd1, bvd2, stschg_ri, spkr_led} = {bvd1_reg, bvd2_reg, sts_reg, spk_reg};

	// ************************************************************
	// Card clock and clock run
	// ************************************************************
	typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_TURN} cbs_state_type;
	cbs_state_type st_reg, st_next;
	logic [DW-1:0] div_reg, div_next;
	logic cclk_reg, cclk_next, clk_on, toggle;

	// Open drain: only ever pulls low, the card's pull shows as a request
	assign clkrun_n_out = 1'b0;
	assign clkrun_n_oe = is_cb && host_clk_running;
	assign card_clk_req = is_cb && !clkrun_n_oe && !clkrun_n_s;
	assign clk_on = is_cb && (host_clk_running || card_clk_req || !crst_n_reg || st_reg != S_IDLE);
	assign toggle = div_reg == DW'(HALF - 1) && (clk_on || cclk_reg);
	assign cclk_rise = toggle && !cclk_reg;

	always_comb begin
		div_next = '0;
		cclk_next = cclk_reg;
		// A stopped clock always finishes its high half so no runt pulse
		if (clk_on || cclk_reg) begin
			div_next = toggle ? '0 : div_reg + 1'b1;
		end
		if (toggle) begin
			cclk_next = !cclk_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			div_reg <= '0;
			cclk_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			cclk_reg <= cclk_next;
		end
	end
	assign cclk = cclk_reg;

	// ************************************************************
	// Bus master engine
	// ************************************************************
	logic [cbs_pkg::FIFO_W-1:0] fifo_data;
	logic fifo_valid, fifo_pop, is_write, is_io, start;
	logic [3:0] cmd_reg, cmd_next, left_reg, left_next, be_reg, be_next;
	logic [31:0] cad_reg, cad_next, rdd_reg, rdd_next;
	logic cad_oe_reg, cad_oe_next, frame_reg, frame_next, irdy_reg, irdy_next, rdv_reg, rdv_next;

	cbs_fifo #(.WIDTH(cbs_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) wr_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({wr_be, wr_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	assign is_write = cmd_reg[0];
	assign is_io = req_cmd[3:1] == cbs_pkg::CMD_IO_READ[3:1];
	assign req_ready = cclk_rise && st_reg == S_IDLE && crst_n_reg;
	assign start = req_ready && req_valid;
	// Completed write phase frees the buffer head
	assign fifo_pop = cclk_rise && st_reg == S_DATA && irdy_reg && !trdy_n_s && is_write;

	always_comb begin
		st_next = st_reg;
		cmd_next = cmd_reg;
		left_next = left_reg;
		be_next = be_reg;
		cad_next = cad_reg;
		cad_oe_next = cad_oe_reg;
		frame_next = frame_reg;
		irdy_next = irdy_reg;
		rdd_next = rdd_reg;
		rdv_next = 1'b0;
		if (!crst_n_reg) begin
			st_next = S_IDLE;
			cad_oe_next = 1'b0;
			frame_next = 1'b0;
			irdy_next = 1'b0;
		end else if (cclk_rise) begin
			case (st_reg)
				S_IDLE: begin
					if (start) begin
						st_next = S_ADDR;
						cmd_next = req_cmd;
						left_next = req_len;
						// Memory and config carry double-word addresses
						cad_next = is_io ? req_addr : {req_addr[31:2], 2'b00};
						cad_oe_next = 1'b1;
						frame_next = 1'b1;
					end
				end
				S_ADDR: begin
					st_next = S_DATA;
					cad_oe_next = is_write;
					frame_next = left_reg != 4'h0;
					be_next = 4'h0;
				end
				S_DATA: begin
					if (irdy_reg && !trdy_n_s) begin
						irdy_next = 1'b0;
						if (!is_write) begin
							rdd_next = cad_s;
							rdv_next = 1'b1;
						end
						if (left_reg == 4'h0) begin
							st_next = S_TURN;
							cad_oe_next = 1'b0;
						end else begin
							left_next = left_reg - 1'b1;
							frame_next = left_reg != 4'h1;
						end
					end else if (!irdy_reg) begin
						// Empty buffer stalls the phase with initiator ready high
						if (!is_write) begin
							irdy_next = 1'b1;
							be_next = 4'hf;
						end else if (fifo_valid) begin
							irdy_next = 1'b1;
							cad_next = fifo_data[31:0];
							be_next = fifo_data[35:32];
						end
					end
				end
				S_TURN: begin
					st_next = S_IDLE;
				end
				default: begin
					st_next = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_reg <= S_IDLE;
			cmd_reg <= 4'h0;
			left_reg <= 4'h0;
			be_reg <= 4'h0;
			cad_reg <= 32'h0;
			cad_oe_reg <= 1'b0;
			frame_reg <= 1'b0;
			irdy_reg <= 1'b0;
			rdd_reg <= 32'h0;
			rdv_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cmd_reg <= cmd_next;
			left_reg <= left_next;
			be_reg <= be_next;
			cad_reg <= cad_next;
			cad_oe_reg <= cad_oe_next;
			frame_reg <= frame_next;
			irdy_reg <= irdy_next;
			rdd_reg <= rdd_next;
			rdv_reg <= rdv_next;
		end
	end

	assign cad_out = cad_reg;
	assign cad_oe = cad_oe_reg;
	assign cbe_n_out = (st_reg == S_ADDR) ? cmd_reg : ~be_reg;
	assign cbe_n_oe = st_reg == S_ADDR || st_reg == S_DATA;
	assign frame_n_out = !frame_reg;
	assign frame_n_oe = st_reg != S_IDLE;
	assign irdy_n_out = !irdy_reg;
	assign irdy_n_oe = st_reg == S_DATA || st_reg == S_TURN;
	assign rd_valid = rdv_reg;
	assign rd_data = rdd_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_crst_no_card: assert property (@(posedge clk_sys) disable iff (reset) !is_cb |=> !crst_n)
		else $error("card reset released without a bus card");
	chk_cclk_high: assert property (@(posedge clk_sys) disable iff (reset) $rose(cclk) |-> cclk [*8])
		else $error("card clock high half wrong length");
	chk_clkrun_show: assert property (@(posedge clk_sys) disable iff (reset)
		(clkrun_n_oe && !clkrun_n_out) == (type_valid && card_type == 2'h2 && host_clk_running))
		else $error("clock run does not mirror host clock");
	chk_addr_cmd: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(frame_n_oe) |-> cad_oe && cbe_n_out == cmd_reg && !frame_n_out)
		else $error("address phase lacks command or address");
	chk_dword_addr: assert property (@(posedge clk_sys) disable iff (reset)
		st_reg == S_ADDR && cmd_reg[3:1] != 3'b001 |-> cad_out[1:0] == 2'b00)
		else $error("memory address not double-word aligned");
	chk_be_lanes: assert property (@(posedge clk_sys) disable iff (reset)
		st_reg == S_DATA && irdy_reg |-> cbe_n_out == ~be_reg && cbe_n_oe)
		else $error("byte enables not driven in data phase");
	chk_rd_both: assert property (@(posedge clk_sys) disable iff (reset)
		rd_valid |-> $past(irdy_reg) && !$past(trdy_n_s) && rd_data == $past(cad_s))
		else $error("read data taken without both ready");
	chk_idle_pins: assert property (@(posedge clk_sys) disable iff (reset)
		!type_valid && !crst_n |-> !clkrun_n_oe ##1 (!cad_oe && !frame_n_oe))
		else $error("card pins driven before type decode");
	chk_mfs_map: assert property (@(posedge clk_sys) disable iff (reset)
		type_valid && type_reg == cbs_pkg::CBS_CARD_16BIT && !io_card_mode |=> bvd1 == $past(mfs1_s))
		else $error("battery detect 1 not mapped");
endmodule : cbs_socket

// [cbs_card_model.sv]
// Behavioural card beyond the socket: a target memory of 16 words.
// Assumes the bridge drives the card clock and reads trdy through its own synchronisers.
`timescale 1ns/10ps
module cbs_card_model (
	input wire logic clk_sys,
	input wire logic cclk,
	input wire logic crst_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [31:0] cad,
	input wire logic [3:0] cbe_n,
	output logic trdy_n,
	output logic [31:0] cad_drv,
	output logic clk_pull_n
);
	logic [31:0] mem [16];
	logic [31:0] addr_seen;
	logic [31:0] s_cad;
	logic [3:0] cmd_seen;
	logic [3:0] s_cbe;
	logic [3:0] idx;
	logic s_frame;
	logic s_irdy;
	logic active;
	logic want_clk;
	int slow;
	int wait_cnt;
	// Snapshot before the edge, so same-edge updates of the bridge never race
	always @(negedge clk_sys) begin
		s_frame = frame_n;
		s_irdy = irdy_n;
		s_cad = cad;
		s_cbe = cbe_n;
	end
	assign clk_pull_n = ~want_clk;
	initial begin
		foreach (mem[i]) mem[i] = 32'h0;
		active = 1'b0;
		trdy_n = 1'b1;
		cad_drv = 32'h5a5a_5a5a;
		slow = 0;
		want_clk = 1'b0;
		wait_cnt = 0;
	end
	always @(posedge cclk) begin
		if (!crst_n) begin
			active = 1'b0;
			trdy_n <= 1'b1;
		end else if (!active) begin
			if (!s_frame) begin
				active = 1'b1;
				addr_seen = s_cad;
				cmd_seen = s_cbe;
				idx = s_cad[5:2];
				wait_cnt = $urandom_range(slow, 0);
			end
		end else if (!s_irdy && !trdy_n) begin
			for (int b = 0; b < 4; b++) begin
				if (cmd_seen[0] && !s_cbe[b]) mem[idx][8*b +: 8] = s_cad[8*b +: 8];
			end
			idx = idx + 4'h1;
			trdy_n <= 1'b1;
			// Released lines show the inverse, never a stale copy
			cad_drv <= ~cad_drv;
			wait_cnt = $urandom_range(slow, 0);
			if (s_frame) active = 1'b0;
		end else if (wait_cnt > 0) begin
			wait_cnt--;
		end else begin
			trdy_n <= 1'b0;
			if (!cmd_seen[0]) cad_drv <= mem[idx];
		end
	end
endmodule : cbs_card_model

// [tb.sv]
// Self-checking bench for the card socket block with a card model.
// Assumes the socket pins are resolved here, with pull-ups on released lines.
`timescale 1ns/10ps
`define CMP(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
module tb;
	logic clk_sys, reset, mfs1_pin, mfs2_pin, io_card_mode, host_clk_running, req_valid, wr_valid, ok;
	logic [1:0] cd_n_pin, vs_pin, card_type;
	logic [3:0] req_cmd, req_len, wr_be, be, cbe_n_out;
	logic [31:0] req_addr, wr_data, d, rd_data, cad_out, card_cad;
	logic [31:0] exp_mem [16];
	logic [31:0] rdq [$];
	logic [3:0] wcmd [3];
	logic [3:0] rcmd [3];
	logic card_present, type_valid, bvd1, bvd2, stschg_ri, spkr_led, card_clk_req, cclk, clkrun_n_out;
	logic clkrun_n_oe, crst_n, req_ready, wr_ready, rd_valid, cad_oe, cbe_n_oe, frame_n_out, frame_n_oe;
	logic irdy_n_out, irdy_n_oe, trdy_n, clk_pull_n;
	int error_cnt, checks_done, n, seed;
	time t0;
	wire clkrun_w = (clkrun_n_oe ? clkrun_n_out : 1'b1) & clk_pull_n;
	wire [31:0] cad_w = cad_oe ? cad_out : card_cad;
	cbs_socket #(.FIFO_DEPTH(cbs_pkg::FIFO_DEPTH)) DUT (.clk_sys(clk_sys), .reset(reset), .cd_n_pin(cd_n_pin),
		.vs_pin(vs_pin), .mfs1_pin(mfs1_pin), .mfs2_pin(mfs2_pin), .io_card_mode(io_card_mode),
		.card_present(card_present), .card_type(card_type), .type_valid(type_valid), .bvd1(bvd1), .bvd2(bvd2),
		.stschg_ri(stschg_ri), .spkr_led(spkr_led), .host_clk_running(host_clk_running),
		.card_clk_req(card_clk_req), .cclk(cclk), .clkrun_n_in(clkrun_w), .clkrun_n_out(clkrun_n_out),
		.clkrun_n_oe(clkrun_n_oe), .crst_n(crst_n), .req_valid(req_valid), .req_ready(req_ready),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .wr_be(wr_be), .rd_valid(rd_valid), .rd_data(rd_data), .cad_in(cad_w),
		.cad_out(cad_out), .cad_oe(cad_oe), .cbe_n_out(cbe_n_out), .cbe_n_oe(cbe_n_oe),
		.frame_n_out(frame_n_out), .frame_n_oe(frame_n_oe), .irdy_n_out(irdy_n_out), .irdy_n_oe(irdy_n_oe),
		.trdy_n_in(trdy_n));
	cbs_card_model card (.clk_sys(clk_sys), .cclk(cclk), .crst_n(crst_n),
		.frame_n(frame_n_oe ? frame_n_out : 1'b1), .irdy_n(irdy_n_oe ? irdy_n_out : 1'b1), .cad(cad_w),
		.cbe_n(cbe_n_oe ? cbe_n_out : 4'hf), .trdy_n(trdy_n), .cad_drv(card_cad), .clk_pull_n(clk_pull_n));
	// *****
	// Helpers
	// *****
	function automatic logic [1:0] exp_type(input logic [1:0] cd, input logic [1:0] vs);
		if (cd == 2'b11) return 2'h0;
		if (cd != 2'b00) return 2'h3;
		return vs[0] ? 2'h1 : 2'h2;
	endfunction : exp_type
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] e);
		for (int b = 0; b < 4; b++) if (e[b]) o[8*b +: 8] = w[8*b +: 8];
		return o;
	endfunction : merge
	task automatic settle(input logic [1:0] cd, input logic [1:0] vs);
		@(negedge clk_sys);
		cd_n_pin = cd;
		vs_pin = vs;
		repeat (4) @(negedge clk_sys);
		n = 0;
		while (type_valid !== 1'b1 && n < 400) begin @(negedge clk_sys); n++; end
		`CMP("type_valid", 1'b1, type_valid)
		`CMP("card_type", exp_type(cd, vs), card_type)
		`CMP("card_present", cd != 2'b11, card_present)
	endtask : settle
	task automatic push(input logic [31:0] w, input logic [3:0] e, output logic acc);
		@(negedge clk_sys);
		wr_valid = 1'b1;
		wr_data = w;
		wr_be = e;
		acc = wr_ready;
		@(negedge clk_sys);
		wr_valid = 1'b0;
	endtask : push
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] len);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_cmd = cmd;
		req_addr = a;
		req_len = len;
		n = 0;
		while (req_ready !== 1'b1 && n < 2000) begin @(negedge clk_sys); n++; end
		`CMP("req_taken", 1'b1, req_ready)
		@(negedge clk_sys);
		req_valid = 1'b0;
		n = 0;
		while (irdy_n_oe !== 1'b1 && n < 100) begin @(negedge clk_sys); n++; end
		n = 0;
		while (irdy_n_oe === 1'b1 && n < 20000) begin @(negedge clk_sys); n++; end
		`CMP("xfer_done", 1'b0, irdy_n_oe)
		repeat (4) @(negedge clk_sys);
		`CMP("addr", (cmd[3:1] == 3'h1) ? a : {a[31:2], 2'b00}, card.addr_seen)
		`CMP("cmd", cmd, card.cmd_seen)
	endtask : xfer
	task automatic toggles(input int cyc, output int cnt);
		logic last;
		last = cclk;
		cnt = 0;
		repeat (cyc) begin @(negedge clk_sys); if (cclk !== last) cnt++; last = cclk; end
	endtask : toggles
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	always @(negedge clk_sys) if (rd_valid === 1'b1) rdq.push_back(rd_data);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Expected run is a few thousand cycles; 30k leaves ample margin
	initial begin
		#300000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected done seen hang");
		wrap_up;
	end
	// *****
	// Scenarios
	// *****
	initial begin
		{reset, host_clk_running} = 2'b11;
		{mfs1_pin, mfs2_pin, io_card_mode, req_valid, wr_valid} = 5'h0;
		{cd_n_pin, vs_pin, req_cmd, req_len, wr_be, req_addr, wr_data} = '0;
		cd_n_pin = 2'b11;
		{error_cnt, checks_done} = 0;
		wcmd = '{cbs_pkg::CMD_MEM_WRITE, cbs_pkg::CMD_IO_WRITE, cbs_pkg::CMD_CFG_WRITE};
		rcmd = '{cbs_pkg::CMD_MEM_READ, cbs_pkg::CMD_IO_READ, cbs_pkg::CMD_CFG_READ};
		foreach (exp_mem[i]) exp_mem[i] = 32'h0;
		seed = $urandom(1);
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		settle(2'b11, 2'b00);
		`CMP("crst_n_empty", 1'b0, crst_n)
		`CMP("cad_oe_empty", 1'b0, cad_oe)
		settle(2'b10, 2'b00);
		settle(2'b00, 2'b01);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			{io_card_mode, mfs2_pin, mfs1_pin} = i[2:0];
			repeat (8) @(negedge clk_sys);
			`CMP("bvd1", !i[2] & i[0], bvd1)
			`CMP("stschg_ri", i[2] & !i[0], stschg_ri)
			`CMP("bvd2", !i[2] & i[1], bvd2)
			`CMP("spkr_led", i[2] & i[1], spkr_led)
		end
		`CMP("crst_n_16bit", 1'b0, crst_n)
		settle(2'b00, 2'b00);
		n = 0;
		while (crst_n !== 1'b1 && n < 1000) begin @(negedge clk_sys); n++; end
		`CMP("crst_n_release", 1'b1, crst_n)
		`CMP("clkrun_drive", 1'b1, clkrun_n_oe)
		@(posedge cclk);
		t0 = $time;
		@(posedge cclk);
		`CMP("cclk_period", 64'd160, $time - t0)
		// Fill the buffer until it refuses, then drain it to a slow card
		for (int i = 0; i < 9; i++) begin
			d = $urandom;
			push(d, 4'hf, ok);
			`CMP("fifo_accept", i < 8, ok)
			if (i < 8) exp_mem[i] = d;
		end
		card.slow = 3;
		xfer(cbs_pkg::CMD_MEM_WRITE, 32'h0000_0003, 4'h7);
		for (int i = 0; i < 8; i++) `CMP("burst_wr", exp_mem[i], card.mem[i])
		for (int k = 0; k < 3; k++) begin
			d = $urandom;
			be = 4'($urandom_range(15, 0));
			push(d, be, ok);
			exp_mem[k] = merge(exp_mem[k], d, be);
			xfer(wcmd[k], 32'(k * 4 + 1), 4'h0);
			`CMP("lane_wr", exp_mem[k], card.mem[k])
		end
		rdq.delete();
		xfer(cbs_pkg::CMD_MEM_READ, 32'h0, 4'h7);
		`CMP("burst_rd_cnt", 8, rdq.size())
		for (int i = 0; i < 8 && i < rdq.size(); i++) `CMP("burst_rd", exp_mem[i], rdq[i])
		for (int k = 0; k < 3; k++) begin
			rdq.delete();
			xfer(rcmd[k], 32'(k * 4 + 2), 4'h0);
			`CMP("single_rd", exp_mem[k], (rdq.size() > 0) ? rdq[0] : ~exp_mem[k])
		end
		// Host clock stops; the card must ask for its clock
		@(negedge clk_sys);
		host_clk_running = 1'b0;
		repeat (40) @(negedge clk_sys);
		`CMP("clkrun_release", 1'b0, clkrun_n_oe)
		toggles(32, n);
		`CMP("cclk_stopped", 0, n)
		card.want_clk = 1'b1;
		toggles(40, n);
		`CMP("cclk_restart", 1'b1, n > 0)
		`CMP("clk_req", 1'b1, card_clk_req)
		rdq.delete();
		xfer(cbs_pkg::CMD_MEM_READ, 32'h4, 4'h0);
		`CMP("req_clk_rd", exp_mem[1], (rdq.size() > 0) ? rdq[0] : ~exp_mem[1])
		card.want_clk = 1'b0;
		host_clk_running = 1'b1;
		settle(2'b11, 2'b00);
		`CMP("crst_n_removed", 1'b0, crst_n)
		wrap_up;
	end
endmodule : tb
